// ==== src/wpb_defs.svh ====
`ifndef WPB_DEFS_SVH
`define WPB_DEFS_SVH

// status memory word offsets
`define WPB_OFS_WRITE_START 6'h05
`define WPB_OFS_REGION_SIZE 6'h08
`define WPB_OFS_READ_START 6'h21
`define WPB_OFS_FREEZE 6'h22
`define WPB_OFS_READ_POS 6'h23
`define WPB_OFS_FILL 6'h24
`define WPB_OFS_STATUS 6'h25

// reset values
`define WPB_RST_WRITE_START 16'h0000
`define WPB_RST_REGION_SIZE 16'h0000
`define WPB_RST_READ_START 16'h0000
`define WPB_RST_FREEZE 16'h0000

// buffer capacities
`define WPB_INT_DEPTH 17'h00800
`define WPB_EXT_DEPTH 17'h10000
`define WPB_INT_MASK 16'h07ff
`define WPB_EXT_MASK 16'hffff

// inline control bits of a data word
`define WPB_BIT_UPDATE_ALL 22
`define WPB_BIT_LOAD_HOLD 21
`define WPB_CHAN_HI 20
`define WPB_CHAN_LO 16

// timing
`define WPB_CLK_KHZ 125000
`define WPB_MAX_RATE_KHZ 9600
`define WPB_MIN_CONV_CYC ((`WPB_CLK_KHZ + `WPB_MAX_RATE_KHZ - 1) / `WPB_MAX_RATE_KHZ)

`endif

// ==== src/wpb_pkg.sv ====
package wpb_pkg;

    typedef enum logic [2:0] {
        WPB_DMA_SIMULTANEOUS,
        WPB_DMA_SEQUENTIAL,
        WPB_LOCAL_MEM_SIMULTANEOUS,
        WPB_LOCAL_MEM_SEQUENTIAL,
        WPB_PARSED_LIST_SIMULTANEOUS,
        WPB_PARSED_LIST_SEQUENTIAL,
        WPB_INLINE_LIST_SIMULTANEOUS,
        WPB_INLINE_LIST_SEQUENTIAL
    } wpb_mode_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] value;
    } wpb_word_t;

    typedef struct packed {
        logic [4:0] chan;
        logic [15:0] value;
        logic hold;
        logic updateAll;
    } wpb_dac_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } wpb_stat_req_t;

    typedef struct packed {
        logic updateAll;
        logic hold;
        logic [4:0] chan;
    } wpb_cl_entry_t;

endpackage

// ==== src/wpb_top.sv ====
`timescale 1ns/1ps
`include "wpb_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// staging fifo between host block writes and the sample buffer
module wpb_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
    logic [PW:0] next_count;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = store[rp];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wp] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wp <= (wp == LAST) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == LAST) ? '0 : rp + 1'b1;
            end
            count <= next_count;
            inReady <= (next_count != FULL);
            outValid <= (next_count != '0);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - fifo 2k or 64k, half-full requests refill
// - end of frame may raise data event
// - on empty buffer hold last output sample
// - regenerate wraps read to region start
// - block writes start at write start index
// - playback starts at read start index
// - size register sets active region length
// - freeze flag stores samples, counters untouched
// - parameters at status words 5,8,33,34
// - load one region while another plays
// - memory selectable internal 2k or external 64k
// - direct channel write accepted any time
// - dma simultaneous updates all on update channel
// - dma sequential updates channels in turn
// - local memory modes to 9.6 MHz, live edits
// - parsed list entries steer hold and update in simultaneous mode
// - inline modes take control from data word
// - one-shot plays buffer once then stops
// - bit22 update all, bit21 hold, 20-16 channel
module wpb_top #(
    parameter int ADDR_W = 16,
    parameter int LIST_DEPTH = 16,
    parameter int STAGE_DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire wpb_pkg::wpb_stat_req_t statReq,
    output logic [15:0] statRdata,
    output logic statRvalid,
    input wire logic blockStart,
    input wire wpb_pkg::wpb_word_t hostWord,
    input wire logic hostValid,
    output logic hostReady,
    input wire logic extMemSel,
    input wire logic regenMode,
    input wire logic oneShot,
    input wire wpb_pkg::wpb_mode_t mode,
    input wire logic [4:0] lastChannel,
    input wire logic [4:0] updateChannel,
    input wire logic updateChannelEn,
    input wire logic [15:0] convDivider,
    input wire logic extConvSel,
    input wire logic extConvClk,
    input wire logic convEnable,
    input wire logic startTrig,
    input wire logic stopTrig,
    input wire logic frameEventEn,
    input wire logic listWrEn,
    input wire logic [3:0] listWrIdx,
    input wire wpb_pkg::wpb_cl_entry_t listWrEntry,
    input wire logic directValid,
    input wire wpb_pkg::wpb_dac_t directWrite,
    output wpb_pkg::wpb_dac_t dacOut,
    output logic dacStrobe,
    output logic halfFullReq,
    output logic frameEvent,
    output logic underrun,
    output logic playing
);
    import wpb_pkg::*;

    localparam logic [15:0] MIN_CONV_CYC = 16'(`WPB_MIN_CONV_CYC);

    function automatic logic [15:0] wpbWrap(input logic [16:0] v, input logic ext);
        wpbWrap = v[15:0] & (ext ? `WPB_EXT_MASK : `WPB_INT_MASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rstPipe;
    logic rstN;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    ////////////////////////////////////////////////////////////////////////////
    // state declarations
    logic [15:0] writeStartIndex;
    logic [15:0] activeRegionSize;
    logic [15:0] readStartIndex;
    logic counterFreezeFlag;
    wpb_word_t sampleMem [0:(1<<ADDR_W)-1];
    wpb_cl_entry_t chanList [0:LIST_DEPTH-1];
    logic [16:0] capacity;
    logic [16:0] fillCount;
    logic [16:0] next_fill;
    logic [15:0] wrPtr;
    logic [15:0] blkCount;
    logic blkActive;
    logic [15:0] rdIdx;
    logic [4:0] seqChan;
    wpb_word_t stageWord;
    logic stageValid;
    logic take;
    logic bufFull;
    logic convTick;
    logic fire;
    logic empty;
    logic regionEnd;
    wpb_word_t curWord;
    wpb_cl_entry_t curEntry;
    wpb_dac_t routed;
    wpb_dac_t pendDac;
    logic pendValid;

    assign capacity = extMemSel ? `WPB_EXT_DEPTH : `WPB_INT_DEPTH;

    ////////////////////////////////////////////////////////////////////////////
    // status memory port
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            writeStartIndex <= `WPB_RST_WRITE_START;
            readStartIndex <= `WPB_RST_READ_START;
            counterFreezeFlag <= 1'b0;
        end else if (statReq.wr) begin
            case (statReq.addr)
                `WPB_OFS_WRITE_START: writeStartIndex <= statReq.wdata;
                `WPB_OFS_READ_START: readStartIndex <= statReq.wdata;
                `WPB_OFS_FREEZE: counterFreezeFlag <= statReq.wdata[0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            statRdata <= 16'h0000;
            statRvalid <= 1'b0;
        end else begin
            statRvalid <= statReq.rd;
            if (statReq.rd) begin
                case (statReq.addr)
                    `WPB_OFS_WRITE_START: statRdata <= writeStartIndex;
                    `WPB_OFS_REGION_SIZE: statRdata <= activeRegionSize;
                    `WPB_OFS_READ_START: statRdata <= readStartIndex;
                    `WPB_OFS_FREEZE: statRdata <= {15'h0000, counterFreezeFlag};
                    `WPB_OFS_READ_POS: statRdata <= rdIdx;
                    `WPB_OFS_FILL: statRdata <= fillCount[16:1];
                    `WPB_OFS_STATUS: statRdata <= {12'h000, blkActive, pendValid, underrun, playing};
                    default: statRdata <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host block write path
    wpb_fifo #(
        .WIDTH($bits(wpb_word_t)),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clk(core_clk),
        .rstN(rstN),
        .inData(hostWord),
        .inValid(hostValid),
        .inReady(hostReady),
        .outData(stageWord),
        .outValid(stageValid),
        .outReady(take)
    );

    assign bufFull = !counterFreezeFlag && (fillCount == capacity);
    assign take = stageValid && blkActive && !bufFull;

    always_ff @(posedge core_clk) begin
        if (take) begin
            sampleMem[wrPtr] <= stageWord;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            blkActive <= 1'b0;
            wrPtr <= 16'h0000;
            blkCount <= 16'h0000;
        end else if (blockStart) begin
            blkActive <= 1'b1;
            wrPtr <= writeStartIndex;
            blkCount <= 16'h0000;
        end else if (take) begin
            wrPtr <= wpbWrap({1'b0, wrPtr} + 17'h00001, extMemSel);
            if (!counterFreezeFlag) begin
                blkCount <= blkCount + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            activeRegionSize <= `WPB_RST_REGION_SIZE;
        end else if (statReq.wr && statReq.addr == `WPB_OFS_REGION_SIZE) begin
            activeRegionSize <= statReq.wdata;
        end else if (take && !counterFreezeFlag) begin
            activeRegionSize <= blkCount;
        end
    end

    always_ff @(posedge core_clk) begin
        if (listWrEn) begin
            chanList[listWrIdx] <= listWrEntry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion clock: internal divider or synchronised pin
    logic [15:0] divCnt;
    logic [15:0] divLimit;
    logic divTick;
    logic [2:0] extSync;
    logic extLevel;
    logic extRise;

    assign divLimit = (convDivider < MIN_CONV_CYC) ? MIN_CONV_CYC : convDivider;
    assign divTick = (divCnt >= divLimit - 16'h0001);
    assign extRise = (extSync[1] == extSync[2]) && extSync[1] && !extLevel;
    assign convTick = extConvSel ? extRise : divTick;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            divCnt <= 16'h0000;
        end else if (divTick || !playing) begin
            divCnt <= 16'h0000;
        end else begin
            divCnt <= divCnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            extSync <= 3'h0;
            extLevel <= 1'b0;
        end else begin
            extSync <= {extSync[1:0], extConvClk};
            if (extSync[1] == extSync[2]) begin
                extLevel <= extSync[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // playback sequencer
    assign empty = !regenMode && (fillCount == 17'h00000);
    assign fire = playing && convTick && !empty;
    assign regionEnd = (rdIdx >= activeRegionSize);
    assign curWord = sampleMem[wpbWrap({1'b0, readStartIndex} + {1'b0, rdIdx}, extMemSel)];
    assign curEntry = chanList[seqChan[3:0]];

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            playing <= 1'b0;
        end else if (stopTrig || !convEnable) begin
            playing <= 1'b0;
        end else if (startTrig) begin
            playing <= 1'b1;
        end else if (fire && regionEnd && oneShot) begin
            playing <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rdIdx <= 16'h0000;
            seqChan <= 5'h00;
        end else if (startTrig && !playing) begin
            rdIdx <= 16'h0000;
            seqChan <= 5'h00;
        end else if (fire) begin
            rdIdx <= regionEnd ? 16'h0000 : rdIdx + 16'h0001;
            seqChan <= (seqChan >= lastChannel) ? 5'h00 : seqChan + 5'h01;
        end
    end

    always_comb begin
        next_fill = fillCount;
        if (take && !counterFreezeFlag && !(fire && !regenMode)) begin
            next_fill = fillCount + 17'h00001;
        end else if (fire && !regenMode && !(take && !counterFreezeFlag)) begin
            next_fill = fillCount - 17'h00001;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            fillCount <= 17'h00000;
            halfFullReq <= 1'b0;
            frameEvent <= 1'b0;
            underrun <= 1'b0;
        end else begin
            fillCount <= next_fill;
            halfFullReq <= !regenMode && (fillCount > (capacity >> 1)) && (next_fill <= (capacity >> 1));
            frameEvent <= fire && regionEnd && frameEventEn;
            if (playing && convTick && empty) begin
                underrun <= 1'b1;
            end else if (startTrig && !playing) begin
                underrun <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel routing per mode
    always_comb begin
        routed.value = curWord.value;
        routed.chan = seqChan;
        routed.hold = 1'b0;
        routed.updateAll = 1'b0;
        case (mode)
            WPB_DMA_SIMULTANEOUS, WPB_LOCAL_MEM_SIMULTANEOUS: begin
                routed.hold = 1'b1;
                routed.updateAll = updateChannelEn && (seqChan == updateChannel);
            end
            WPB_DMA_SEQUENTIAL, WPB_LOCAL_MEM_SEQUENTIAL: begin
                routed.chan = seqChan;
            end
            WPB_PARSED_LIST_SIMULTANEOUS: begin
                routed.chan = curEntry.chan;
                routed.hold = curEntry.hold;
                routed.updateAll = curEntry.updateAll;
            end
            WPB_PARSED_LIST_SEQUENTIAL: begin
                routed.chan = curEntry.chan;
            end
            WPB_INLINE_LIST_SIMULTANEOUS: begin
                routed.chan = curWord.ctrl[`WPB_CHAN_HI-16:`WPB_CHAN_LO-16];
                routed.hold = curWord.ctrl[`WPB_BIT_LOAD_HOLD-16];
                routed.updateAll = curWord.ctrl[`WPB_BIT_UPDATE_ALL-16];
            end
            WPB_INLINE_LIST_SEQUENTIAL: begin
                routed.chan = curWord.ctrl[`WPB_CHAN_HI-16:`WPB_CHAN_LO-16];
            end
            default: begin
                routed.chan = seqChan;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter port: direct writes win, a colliding sample waits until directValid drops
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            dacOut <= '0;
            dacStrobe <= 1'b0;
            pendDac <= '0;
            pendValid <= 1'b0;
        end else if (directValid) begin
            dacOut <= directWrite;
            dacStrobe <= 1'b1;
            if (fire) begin
                pendDac <= routed;
                pendValid <= 1'b1;
            end
        end else if (pendValid) begin
            dacOut <= pendDac;
            dacStrobe <= 1'b1;
            pendValid <= fire;
            pendDac <= routed;
        end else if (fire) begin
            dacOut <= routed;
            dacStrobe <= 1'b1;
        end else begin
            dacStrobe <= 1'b0;
        end
    end
endmodule

// ==== verif/wpb_props.sv ====
`timescale 1ns/1ps
module wpb_props
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire wpb_pkg::wpb_stat_req_t statReq,
    input wire logic [15:0] statRdata,
    input wire logic statRvalid,
    input wire logic convEnable,
    input wire logic startTrig,
    input wire logic stopTrig,
    input wire logic frameEventEn,
    input wire logic directValid,
    input wire wpb_pkg::wpb_dac_t directWrite,
    input wire wpb_pkg::wpb_dac_t dacOut,
    input wire logic dacStrobe,
    input wire logic frameEvent,
    input wire logic underrun,
    input wire logic playing
);
    import wpb_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    sequence rdTaken;
        statReq.rd;
    endsequence

    sequence startTaken;
        startTrig && convEnable && !stopTrig && !playing;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property (rdTaken |=> statRvalid)
        else $error("status read not answered");
    rvalid_cause_a: assert property (statRvalid |-> $past(statReq.rd))
        else $error("status answer without read");
    rdata_hold_a: assert property (!statRvalid |-> $stable(statRdata))
        else $error("read data moved without answer");
    start_play_a: assert property (startTaken |=> playing)
        else $error("start did not begin playback");
    stop_play_a: assert property (!convEnable |-> ##[1:2] !playing)
        else $error("playback kept running while disabled");
    direct_apply_a: assert property (directValid |=> dacStrobe && dacOut == $past(directWrite))
        else $error("direct write not applied");
    level_hold_a: assert property ($changed(dacOut) |-> dacStrobe)
        else $error("output moved without converter write");
    underrun_sticky_a: assert property (underrun && !startTrig |=> underrun)
        else $error("underrun dropped before restart");
    frame_gate_a: assert property (frameEvent |-> $past(frameEventEn))
        else $error("frame event while disabled");
endmodule

// ==== verif/wpb_host_model.sv ====
`timescale 1ns/1ps
module wpb_host_model
(
    input wire logic clk,
    input wire logic hostReady,
    output wpb_pkg::wpb_word_t hostWord,
    output logic hostValid,
    output logic blockStart
);
    import wpb_pkg::*;

    int seedH = 74916;

    initial begin
        hostWord = '0;
        hostValid = 1'b0;
        blockStart = 1'b0;
    end

    task automatic open_block();
        blockStart = 1'b1;
        @(posedge clk);
        #1 blockStart = 1'b0;
    endtask

    // holds the word until taken, then stalls now and then
    task automatic send(input wpb_word_t w);
        int k;
        hostWord = w;
        hostValid = 1'b1;
        @(posedge clk);
        for (k = 0; k < 3000 && hostReady !== 1'b1; k++) @(posedge clk);
        #1;
        if ($random(seedH) % 4 == 0) begin
            hostValid = 1'b0;
            hostWord = ~w;
            @(posedge clk);
            #1;
        end
    endtask

    // released bus shows no stale word
    task automatic idle();
        hostValid = 1'b0;
        hostWord = ~hostWord;
        @(posedge clk);
        #1;
    endtask
endmodule

// ==== verif/waveform_playback_buffer_tb_top.sv ====
`timescale 1ns/1ps
module waveform_playback_buffer_tb_top;
    import wpb_pkg::*;

    logic core_clk, rst_n, statRvalid, blockStart, hostValid, hostReady, extMemSel, regenMode, oneShot;
    logic updateChannelEn, convEnable, startTrig, stopTrig, frameEventEn, listWrEn, directValid;
    logic dacStrobe, halfFullReq, frameEvent, underrun, playing;
    logic [15:0] statRdata, convDivider, d;
    logic [4:0] lastChannel, updateChannel;
    logic [3:0] listWrIdx;
    logic [23:0] mem [0:2047];
    logic [5:0] regAddr [0:3] = '{6'h05, 6'h08, 6'h21, 6'h22};
    wpb_stat_req_t statReq;
    wpb_word_t hostWord;
    wpb_mode_t mode;
    wpb_cl_entry_t listWrEntry;
    wpb_dac_t directWrite, dacOut;
    int errTotal = 0, totalChecks = 0, seed = 74916, frames = 0, halfs = 0, i, k, n, w, f0, hit;

    wpb_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .statReq(statReq), .statRdata(statRdata),
        .statRvalid(statRvalid), .blockStart(blockStart), .hostWord(hostWord), .hostValid(hostValid),
        .hostReady(hostReady), .extMemSel(extMemSel), .regenMode(regenMode), .oneShot(oneShot), .mode(mode),
        .lastChannel(lastChannel), .updateChannel(updateChannel), .updateChannelEn(updateChannelEn),
        .convDivider(convDivider), .extConvSel(1'b0), .extConvClk(1'b0), .convEnable(convEnable),
        .startTrig(startTrig), .stopTrig(stopTrig), .frameEventEn(frameEventEn), .listWrEn(listWrEn),
        .listWrIdx(listWrIdx), .listWrEntry(listWrEntry), .directValid(directValid), .directWrite(directWrite),
        .dacOut(dacOut), .dacStrobe(dacStrobe), .halfFullReq(halfFullReq), .frameEvent(frameEvent),
        .underrun(underrun), .playing(playing));

    wpb_host_model host_u (.clk(core_clk), .hostReady(hostReady), .hostWord(hostWord), .hostValid(hostValid),
        .blockStart(blockStart));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (frameEvent === 1'b1) frames <= frames + 1;
        if (halfFullReq === 1'b1) halfs <= halfs + 1;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        errTotal++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic stat_wr(input logic [5:0] a, input logic [15:0] v);
        statReq = '{1'b1, 1'b0, a, v};
        step();
        statReq = '0;
        step();
    endtask

    task automatic stat_rd(input logic [5:0] a, output logic [15:0] v);
        statReq = '{1'b0, 1'b1, a, 16'h0000};
        step();
        statReq = '0;
        chk("statRvalid", 24'h000001, 24'(statRvalid));
        v = statRdata;
        step();
    endtask

    task automatic pulse_start(input logic stop);
        if (stop) stopTrig = 1'b1;
        else startTrig = 1'b1;
        step();
        startTrig = 1'b0;
        stopTrig = 1'b0;
    endtask

    task automatic next_sample();
        step();
        for (k = 0; k < 60 && dacStrobe !== 1'b1; k++) step();
        chk("dacStrobe", 24'h000001, 24'(dacStrobe));
    endtask

    function automatic logic [15:0] reg_exp(input logic [5:0] a, input logic [15:0] v);
        return (a == 6'h22) ? (v & 16'h0001) : v;
    endfunction

    function automatic int slot(input int base, input int sz, input int j);
        return base + j % sz;
    endfunction

    task automatic collect(input int cnt, input int base, input int sz);
        int j;
        for (j = 0; j < cnt; j++) begin
            next_sample();
            chk("sample", 24'(mem[slot(base, sz, j)][15:0]), 24'(dacOut.value));
            if (mode == WPB_INLINE_LIST_SIMULTANEOUS || mode == WPB_INLINE_LIST_SEQUENTIAL)
                chk("inline", 24'(mem[slot(base, sz, j)][22:16] & {mode[0] ? 2'b00 : 2'b11, 5'h1f}),
                    24'({dacOut.updateAll, dacOut.hold, dacOut.chan}));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        statReq = '0; extMemSel = 1'b0; regenMode = 1'b0; oneShot = 1'b0; mode = WPB_DMA_SEQUENTIAL;
        lastChannel = 5'h07; updateChannel = 5'h03; updateChannelEn = 1'b1; convDivider = 16'h000e;
        convEnable = 1'b0; startTrig = 1'b0; stopTrig = 1'b0; frameEventEn = 1'b1; listWrEn = 1'b0;
        listWrIdx = 4'h0; listWrEntry = '0; directValid = 1'b0; directWrite = '0; rst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) step();
        for (i = 0; i < 4; i++) begin
            stat_rd(regAddr[i], d);
            chk("resetValue", 24'h000000, 24'(d));
        end
        stat_rd(6'h10, d);
        chk("unmapped", 24'h000000, 24'(d));
        for (i = 0; i < 4; i++) begin
            w = $random(seed) & 16'h07ff;
            stat_wr(regAddr[i], 16'(w));
            stat_rd(regAddr[i], d);
            chk("regReadback", 24'(reg_exp(regAddr[i], 16'(w))), 24'(d));
            stat_wr(regAddr[i], 16'h0000);
        end
        for (i = 0; i < 16; i++) begin
            listWrEn = 1'b1;
            listWrIdx = 4'(i);
            listWrEntry = wpb_cl_entry_t'($random(seed));
            step();
        end
        listWrEn = 1'b0;
        for (i = 0; i < 1030; i++) mem[i] = 24'($random(seed));
        for (i = 0; i < 8; i++) host_u.send(mem[i]);
        host_u.idle();
        repeat (3) step();
        chk("hostReady", 24'h000000, 24'(hostReady));
        host_u.open_block();
        for (i = 8; i < 1030; i++) host_u.send(mem[i]);
        host_u.idle();
        repeat (20) step();
        stat_rd(6'h08, d);
        chk("regionSize", 24'd1029, 24'(d));
        convEnable = 1'b1;
        step();
        pulse_start(1'b0);
        collect(1030, 0, 1030);
        repeat (100) step();
        chk("underrun", 24'h000001, 24'(underrun));
        chk("heldLevel", 24'(mem[1029][15:0]), 24'(dacOut.value));
        chk("halfFull", 24'h000001, 24'(halfs));
        pulse_start(1'b1);
        w = 1100 + ($random(seed) & 255);
        n = 5 + ($random(seed) & 7);
        stat_wr(6'h05, 16'(w));
        host_u.open_block();
        for (i = 0; i < n; i++) begin
            mem[w + i] = 24'($random(seed));
            host_u.send(mem[w + i]);
        end
        host_u.idle();
        repeat (20) step();
        stat_rd(6'h08, d);
        chk("regionSize", 24'(n - 1), 24'(d));
        stat_wr(6'h21, 16'(w));
        regenMode = 1'b1;
        f0 = frames;
        pulse_start(1'b0);
        for (i = 0; i < 8; i++) begin
            mode = wpb_mode_t'(i);
            collect(n, w, n);
        end
        chk("frameEvents", 24'h000001, 24'(frames - f0 >= 7));
        directWrite = wpb_dac_t'($random(seed));
        directValid = 1'b1;
        step();
        directValid = 1'b0;
        chk("directWrite", 24'(directWrite), 24'(dacOut));
        stat_wr(6'h22, 16'h0001);
        stat_wr(6'h05, 16'(w + n));
        host_u.open_block();
        for (i = 0; i < 3; i++) begin
            mem[w + n + i] = 24'($random(seed));
            host_u.send(mem[w + n + i]);
        end
        host_u.idle();
        repeat (20) step();
        stat_wr(6'h22, 16'h0000);
        stat_rd(6'h08, d);
        chk("frozenSize", 24'(n - 1), 24'(d));
        stat_wr(6'h08, 16'h0002);
        stat_wr(6'h21, 16'(w + n));
        next_sample();
        next_sample();
        hit = 1;
        for (i = 0; i < 6; i++) begin
            next_sample();
            if (dacOut.value !== mem[w + n][15:0] && dacOut.value !== mem[w + n + 1][15:0]
                && dacOut.value !== mem[w + n + 2][15:0]) hit = 0;
        end
        chk("newRegion", 24'h000001, 24'(hit));
        oneShot = 1'b1;
        for (k = 0; k < 300 && playing === 1'b1; k++) step();
        chk("oneShotStop", 24'h000000, 24'(playing));
        pulse_start(1'b1);
        convEnable = 1'b0;
        repeat (4) step();
        conclude();
    end
endmodule

bind wpb_top wpb_props props_u (.core_clk(core_clk), .rst_n(rst_n), .statReq(statReq), .statRdata(statRdata),
    .statRvalid(statRvalid), .convEnable(convEnable), .startTrig(startTrig), .stopTrig(stopTrig),
    .frameEventEn(frameEventEn), .directValid(directValid), .directWrite(directWrite), .dacOut(dacOut),
    .dacStrobe(dacStrobe), .frameEvent(frameEvent), .underrun(underrun), .playing(playing));
